// ==== design/btd_pkg.sv ====
// Constants, register map and carrier types of the bus trace debug module
package btd_pkg;

    // ****************************************************************
    // Register indices on the register port
    // ****************************************************************
    localparam logic [3:0] IDX_CMP_A_HIGH = 4'h0;
    localparam logic [3:0] IDX_CMP_A_LOW = 4'h1;
    localparam logic [3:0] IDX_CMP_B_HIGH = 4'h2;
    localparam logic [3:0] IDX_CMP_B_LOW = 4'h3;
    localparam logic [3:0] IDX_FIFO_HIGH = 4'h4;
    localparam logic [3:0] IDX_FIFO_LOW = 4'h5;
    localparam logic [3:0] IDX_CONTROL = 4'h6;
    localparam logic [3:0] IDX_TRIGGER = 4'h7;
    localparam logic [3:0] IDX_STATUS = 4'h8;
    localparam logic [3:0] IDX_FORCE_RST = 4'h9;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTL_ENABLE = 7;
    localparam int CTL_ARM = 6;
    localparam int CTL_TAG = 5;
    localparam int CTL_BREAK_REQUEST_ENABLE = 4;
    localparam int CTL_DIR_A = 3;
    localparam int CTL_DIRQ_A = 2;
    localparam int CTL_DIR_B = 1;
    localparam int CTL_DIRQ_B = 0;
    localparam int TRG_OPCODE = 7;
    localparam int TRG_BEGIN = 6;
    localparam int FRC_RESET_BIT = 0;
    localparam logic [7:0] TRG_WRITE_MASK = 8'hCF;

    // ****************************************************************
    // Reset values and sizes
    // ****************************************************************
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] TRG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [3:0] FIFO_FULL_CNT = 4'h8;
    localparam logic [3:0] FIFO_LAST_CNT = 4'h7;

    // ****************************************************************
    // Trigger modes
    // ****************************************************************
    typedef enum logic [3:0] {
        MODE_A_ONLY = 4'b0000,
        MODE_A_OR_B = 4'b0001,
        MODE_A_THEN_B = 4'b0010,
        MODE_EVENT_B = 4'b0011,
        MODE_A_THEN_EVENT_B = 4'b0100,
        MODE_A_AND_B_DATA = 4'b0101,
        MODE_A_NOT_B_DATA = 4'b0110,
        MODE_INSIDE = 4'b0111,
        MODE_OUTSIDE = 4'b1000
    } btd_mode_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic rw;
        logic fetch;
        logic [15:0] addr;
        logic [7:0] data;
    } btd_bus_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } btd_exec_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic dbg;
        logic [3:0] sel;
        logic [7:0] wdata;
    } btd_reg_req_t;

endpackage

// ==== design/btd_bus_trace_debug.sv ====
// Bus trace debug module: comparators, trigger logic, capture FIFO, registers
`timescale 1ns/1ps
// Summary of operation
// - Debug-host write of 1 forces chip reset
// - Comparator bytes reset zero, write only unarmed
// - FIFO high read no advance; event modes zero
// - FIFO low read advances to next word
// - No FIFO advance while armed; host waits
// - Unarmed low read stores last fetch address
// - Enable cannot set while secure; clear disables
// - Arm write starts run; completion or clear ends
// - Tag bit selects tag or force break
// - Break at trigger end trace, full begin
// - Comparator A read/write qualification
// - Comparator B read/write qualification
// - Trigger register writable unarmed; bits 4,5 zero
// - Opcode-qualify matches executed opcodes only
// - Begin/end select; event modes act begin
// - Nine trigger modes; higher codes never trigger
// - Match flags clear at run start, set on match
// - Arm flag mirrors arm; run completion conditions
// - Valid count clears at start, not decremented
// - Event modes store data byte in low half
// - Inside range bounds inclusive
// - A then event B captures until full
module btd_bus_trace_debug
    import btd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic secure,
    input wire btd_bus_t bus,
    input wire btd_exec_t exec,
    input wire btd_reg_req_t req,
    output logic [7:0] reg_rdata,
    output logic break_req,
    output logic break_tag,
    output logic force_reset
);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    logic [7:0] cmp_a_hi_r;
    logic [7:0] cmp_a_lo_r;
    logic [7:0] cmp_b_hi_r;
    logic [7:0] cmp_b_lo_r;
    logic [7:0] ctl_r;
    logic [7:0] trg_r;
    logic match_a_flag_r;
    logic match_b_flag_r;
    logic a_seen_r;
    logic storing_r;
    logic [3:0] fifo_valid_count_r;
    logic [2:0] wr_ptr_r;
    logic [2:0] rd_ptr_r;
    logic [15:0] last_fetch_r;
    logic [15:0] fifo_mem [8];
    logic [7:0] rdata_r;
    logic break_req_r;
    logic break_tag_r;
    logic force_reset_r;

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic armed;
    logic wr_ctl;
    logic run_start;
    logic enable_nxt;
    logic event_mode;
    logic begin_trace;
    logic rd_fifo_low;
    btd_mode_t mode;

    assign armed = ctl_r[CTL_ARM];
    assign mode = btd_mode_t'(trg_r[3:0]);
    assign wr_ctl = req.wr && (req.sel == IDX_CONTROL);
    assign enable_nxt = req.wdata[CTL_ENABLE] && (ctl_r[CTL_ENABLE] || !secure);
    assign run_start = wr_ctl && enable_nxt && req.wdata[CTL_ARM];
    assign event_mode = (mode == MODE_EVENT_B) || (mode == MODE_A_THEN_EVENT_B);
    assign begin_trace = event_mode || trg_r[TRG_BEGIN];
    assign rd_fifo_low = req.rd && (req.sel == IDX_FIFO_LOW);

    // ****************************************************************
    // Comparators
    // ****************************************************************
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] watch_addr;
    logic watch_valid;
    logic watch_rw;
    logic dir_ok_a;
    logic dir_ok_b;
    logic hit_a;
    logic hit_b;

    assign cmp_a = {cmp_a_hi_r, cmp_a_lo_r};
    assign cmp_b = {cmp_b_hi_r, cmp_b_lo_r};
    // Opcode-qualified matches only look at opcodes that really execute
    assign watch_addr = trg_r[TRG_OPCODE] ? exec.addr : bus.addr;
    assign watch_valid = trg_r[TRG_OPCODE] ? exec.valid : bus.valid;
    assign watch_rw = trg_r[TRG_OPCODE] ? 1'b1 : bus.rw;
    assign dir_ok_a = !ctl_r[CTL_DIRQ_A] || (watch_rw == ctl_r[CTL_DIR_A]);
    assign dir_ok_b = !ctl_r[CTL_DIRQ_B] || (watch_rw == ctl_r[CTL_DIR_B]);
    assign hit_a = armed && watch_valid && (watch_addr == cmp_a) && dir_ok_a;
    assign hit_b = armed && watch_valid && (watch_addr == cmp_b) && dir_ok_b;

    // ****************************************************************
    // Trigger decision
    // ****************************************************************
    logic trig;
    logic in_range;

    assign in_range = (watch_addr >= cmp_a) && (watch_addr <= cmp_b);

    always_comb begin
        trig = 1'b0;
        unique case (trg_r[3:0])
            MODE_A_ONLY: trig = hit_a;
            MODE_A_OR_B: trig = hit_a || hit_b;
            MODE_A_THEN_B: trig = a_seen_r && hit_b;
            MODE_EVENT_B: trig = hit_b;
            MODE_A_THEN_EVENT_B: trig = a_seen_r && hit_b;
            MODE_A_AND_B_DATA: trig = hit_a && (bus.data == cmp_b_lo_r);
            MODE_A_NOT_B_DATA: trig = hit_a && (bus.data != cmp_b_lo_r);
            MODE_INSIDE: trig = armed && watch_valid && in_range;
            MODE_OUTSIDE: trig = armed && watch_valid && !in_range;
            default: trig = 1'b0;
        endcase
    end

    // ****************************************************************
    // Capture decision
    // ****************************************************************
    logic store_en;
    logic [15:0] store_word;
    logic run_done;
    logic [2:0] wr_ptr_nxt;
    logic [3:0] cnt_nxt;

    always_comb begin
        store_en = 1'b0;
        if (armed && !run_start) begin
            if (event_mode) begin
                store_en = trig;
            end else if (begin_trace) begin
                store_en = bus.fetch && (storing_r || trig);
            end else begin
                store_en = bus.fetch;
            end
        end
    end

    assign store_word = event_mode ? {READ_ZERO, bus.data} : bus.addr;
    assign wr_ptr_nxt = store_en ? wr_ptr_r + 3'd1 : wr_ptr_r;
    assign cnt_nxt = (store_en && (fifo_valid_count_r != FIFO_FULL_CNT))
        ? fifo_valid_count_r + 4'd1 : fifo_valid_count_r;
    // Begin trace ends on the eighth stored word, end trace on trigger
    assign run_done = armed && !run_start && (begin_trace
        ? (store_en && (fifo_valid_count_r == FIFO_LAST_CNT))
        : trig);

    // ****************************************************************
    // Comparator registers
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_a_hi_r <= CMP_RESET;
            cmp_a_lo_r <= CMP_RESET;
            cmp_b_hi_r <= CMP_RESET;
            cmp_b_lo_r <= CMP_RESET;
        end else if (clk_en && req.wr && !armed) begin
            if (req.sel == IDX_CMP_A_HIGH) begin
                cmp_a_hi_r <= req.wdata;
            end
            if (req.sel == IDX_CMP_A_LOW) begin
                cmp_a_lo_r <= req.wdata;
            end
            if (req.sel == IDX_CMP_B_HIGH) begin
                cmp_b_hi_r <= req.wdata;
            end
            if (req.sel == IDX_CMP_B_LOW) begin
                cmp_b_lo_r <= req.wdata;
            end
        end
    end

    // ****************************************************************
    // Control and trigger registers
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r <= CTL_RESET;
        end else if (clk_en) begin
            if (wr_ctl) begin
                ctl_r <= req.wdata;
                ctl_r[CTL_ENABLE] <= enable_nxt;
                ctl_r[CTL_ARM] <= enable_nxt && req.wdata[CTL_ARM];
            end else if (run_done) begin
                ctl_r[CTL_ARM] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trg_r <= TRG_RESET;
        end else if (clk_en && req.wr && (req.sel == IDX_TRIGGER) && !armed) begin
            trg_r <= req.wdata & TRG_WRITE_MASK;
        end
    end

    // ****************************************************************
    // Run status and sequence state
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            match_a_flag_r <= 1'b0;
            match_b_flag_r <= 1'b0;
            a_seen_r <= 1'b0;
            storing_r <= 1'b0;
            fifo_valid_count_r <= 4'h0;
        end else if (clk_en) begin
            if (run_start) begin
                match_a_flag_r <= 1'b0;
                match_b_flag_r <= 1'b0;
                a_seen_r <= 1'b0;
                storing_r <= 1'b0;
                fifo_valid_count_r <= 4'h0;
            end else if (armed) begin
                if (hit_a) begin
                    match_a_flag_r <= 1'b1;
                    a_seen_r <= 1'b1;
                end
                if (hit_b) begin
                    match_b_flag_r <= 1'b1;
                end
                if (trig) begin
                    storing_r <= 1'b1;
                end
                fifo_valid_count_r <= cnt_nxt;
            end
        end
    end

    // ****************************************************************
    // Capture FIFO
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= 3'd0;
            rd_ptr_r <= 3'd0;
        end else if (clk_en) begin
            if (run_start) begin
                wr_ptr_r <= 3'd0;
                rd_ptr_r <= 3'd0;
            end else if (armed) begin
                wr_ptr_r <= wr_ptr_nxt;
                // Oldest word first once the run is over; reads stay put meanwhile
                if (run_done) begin
                    rd_ptr_r <= cnt_nxt[3] ? wr_ptr_nxt : 3'd0;
                end
            end else if (rd_fifo_low) begin
                rd_ptr_r <= rd_ptr_r + 3'd1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (clk_en) begin
            if (store_en) begin
                fifo_mem[wr_ptr_r] <= store_word;
            end else if (!armed && rd_fifo_low) begin
                fifo_mem[rd_ptr_r] <= last_fetch_r;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_fetch_r <= 16'h0000;
        end else if (clk_en && bus.valid && bus.fetch) begin
            last_fetch_r <= bus.addr;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [7:0] rd_mux;
    logic [15:0] fifo_head;

    assign fifo_head = fifo_mem[rd_ptr_r];

    always_comb begin
        rd_mux = READ_ZERO;
        case (req.sel)
            IDX_CMP_A_HIGH: rd_mux = cmp_a_hi_r;
            IDX_CMP_A_LOW: rd_mux = cmp_a_lo_r;
            IDX_CMP_B_HIGH: rd_mux = cmp_b_hi_r;
            IDX_CMP_B_LOW: rd_mux = cmp_b_lo_r;
            IDX_FIFO_HIGH: rd_mux = event_mode ? READ_ZERO : fifo_head[15:8];
            IDX_FIFO_LOW: rd_mux = fifo_head[7:0];
            IDX_CONTROL: rd_mux = ctl_r;
            IDX_TRIGGER: rd_mux = trg_r;
            IDX_STATUS: rd_mux = {match_a_flag_r, match_b_flag_r,
                armed && ctl_r[CTL_ENABLE], 1'b0, fifo_valid_count_r};
            IDX_FORCE_RST: rd_mux = READ_ZERO;
            default: rd_mux = READ_ZERO;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= READ_ZERO;
        end else if (clk_en && req.rd) begin
            rdata_r <= rd_mux;
        end
    end

    // ****************************************************************
    // Break and forced reset outputs
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            break_req_r <= 1'b0;
            break_tag_r <= 1'b0;
        end else if (clk_en) begin
            break_req_r <= run_done && ctl_r[CTL_BREAK_REQUEST_ENABLE];
            break_tag_r <= ctl_r[CTL_BREAK_REQUEST_ENABLE] && ctl_r[CTL_TAG];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            force_reset_r <= 1'b0;
        end else if (clk_en) begin
            force_reset_r <= req.wr && req.dbg && (req.sel == IDX_FORCE_RST)
                && req.wdata[FRC_RESET_BIT];
        end
    end

    assign reg_rdata = rdata_r;
    assign break_req = break_req_r;
    assign break_tag = break_tag_r;
    assign force_reset = force_reset_r;

endmodule

// ==== sim/btd_bus_trace_debug_checker.sv ====
// Port checker for the bus trace debug module
`timescale 1ns/1ps
module btd_bus_trace_debug_checker
    import btd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic secure,
    input wire btd_bus_t bus,
    input wire btd_exec_t exec,
    input wire btd_reg_req_t req,
    input wire logic [7:0] reg_rdata,
    input wire logic break_req,
    input wire logic break_tag,
    input wire logic force_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic en_r;
    logic tag_r;
    logic brk_r;
    wire rd_c = clk_en && req.rd && !req.wr;
    wire wr_c = clk_en && req.wr;
    wire frc_c = wr_c && req.dbg && req.sel == IDX_FORCE_RST && req.wdata[FRC_RESET_BIT];
    // ****************
    // Control shadow
    // ****************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= 1'b0;
            tag_r <= 1'b0;
            brk_r <= 1'b0;
        end else if (wr_c && req.sel == IDX_CONTROL) begin
            en_r <= req.wdata[CTL_ENABLE] && (!secure || en_r);
            tag_r <= req.wdata[CTL_TAG];
            brk_r <= req.wdata[CTL_BREAK_REQUEST_ENABLE];
        end
    end
    AST_FRC_SET: assert property (frc_c |=> force_reset)
        else $error("force reset missing");
    AST_FRC_CAUSE: assert property (force_reset |-> $past(frc_c))
        else $error("force reset without host write");
    AST_FRC_READ: assert property (rd_c && req.sel == IDX_FORCE_RST |=> reg_rdata == 8'h00)
        else $error("force reset reg not zero");
    AST_EN_SECURE: assert property (rd_c && req.sel == IDX_CONTROL |=> reg_rdata[7] == en_r)
        else $error("enable bit wrong");
    AST_TAG_LEVEL: assert property ($stable({tag_r, brk_r}) |-> break_tag == (tag_r && brk_r))
        else $error("break type wrong");
    AST_BRK_EN: assert property (break_req |-> $past(brk_r))
        else $error("break while disabled");
    AST_BRK_ONCE: assert property (break_req && clk_en |=> !break_req)
        else $error("break longer than one cycle");
    AST_TRG_ZERO: assert property (rd_c && req.sel == IDX_TRIGGER |=> reg_rdata[5:4] == 2'h0)
        else $error("trigger bits 5:4 not zero");
    AST_STAT_ZERO: assert property (rd_c && req.sel == IDX_STATUS |=> !reg_rdata[4])
        else $error("status bit 4 not zero");
    COV_TAG: cover property (break_req && break_tag);
    COV_FRC: cover property (force_reset);
    COV_FIFO: cover property (rd_c && req.sel == IDX_FIFO_LOW);
endmodule
bind btd_bus_trace_debug btd_bus_trace_debug_checker chk_u (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .secure(secure), .bus(bus), .exec(exec), .req(req),
    .reg_rdata(reg_rdata), .break_req(break_req), .break_tag(break_tag),
    .force_reset(force_reset));

// ==== sim/btd_cpu_model.sv ====
// CPU bus and pipeline model driving the debug module
`timescale 1ns/1ps
module btd_cpu_model
    import btd_pkg::*;
(
    input wire logic clk,
    output btd_bus_t bus,
    output btd_exec_t exec
);
    initial begin
        bus = '0;
        exec = '0;
    end
    // One bus cycle, then the bus is released with inverted values
    task automatic cycle(input logic rw, input logic fe, input logic [15:0] a,
        input logic [7:0] d, input logic ex);
        @(posedge clk);
        bus <= '{1'b1, rw, fe, a, d};
        exec <= '{ex, a};
        @(posedge clk);
        bus <= '{1'b0, ~rw, 1'b0, ~a, ~d};
        exec <= '{1'b0, ~a};
    endtask
endmodule

// ==== sim/tb_btd_bus_trace_debug.sv ====
// Testbench of the bus trace debug module
`timescale 1ns/1ps
module tb_btd_bus_trace_debug;
    import btd_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic secure = 1'b0;
    btd_bus_t bus;
    btd_exec_t exec;
    btd_reg_req_t req = '0;
    logic [7:0] reg_rdata;
    logic [7:0] v1;
    logic [7:0] v2;
    logic break_req;
    logic break_tag;
    logic force_reset;
    int n_errors = 0;
    int check_count = 0;
    int n_brk = 0;
    int n_frc = 0;
    int base;
    logic [7:0] t_trg [17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h08, 8'h09, 8'h0F, 8'h00, 8'h00, 8'h02, 8'h02, 8'h80, 8'h00};
    logic [7:0] t_ctl [17] = '{8'hD0, 8'hD0, 8'hD0, 8'hD0, 8'hD0, 8'hD0, 8'hD0, 8'hD0,
        8'hD0, 8'hD0, 8'hD0, 8'hD4, 8'hDC, 8'hD1, 8'hD3, 8'hD0, 8'hF0};
    logic [16:0] t_hit = 17'h151A7;
    btd_bus_trace_debug dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .secure(secure),
        .bus(bus), .exec(exec), .req(req), .reg_rdata(reg_rdata), .break_req(break_req),
        .break_tag(break_tag), .force_reset(force_reset));
    btd_cpu_model cpu_u (.clk(clk), .bus(bus), .exec(exec));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (break_req === 1'b1)
            n_brk <= n_brk + 1;
        if (force_reset === 1'b1)
            n_frc <= n_frc + 1;
    end
    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] sel, input logic [7:0] d, input logic dbg = 1'b0);
        @(posedge clk);
        req <= '{1'b0, 1'b1, dbg, sel, d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [3:0] sel, output logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, 1'b0, sel, 8'h00};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic rchk(input logic [3:0] sel, input logic [7:0] exp);
        logic [7:0] d;
        rd(sel, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rchk(4'(i), CMP_RESET);
        end
        wr(IDX_FORCE_RST, 8'h01);
        wr(IDX_FORCE_RST, 8'h01, 1'b1);
        rchk(IDX_FORCE_RST, 8'h00);
        chk(16'(n_frc), 16'h0001);
        @(posedge clk);
        secure <= 1'b1;
        wr(IDX_CONTROL, 8'h80);
        rchk(IDX_CONTROL, 8'h00);
        @(posedge clk);
        secure <= 1'b0;
        wr(IDX_CONTROL, 8'h80);
        rchk(IDX_CONTROL, 8'h80);
        wr(IDX_CMP_A_HIGH, 8'h12);
        wr(IDX_CMP_A_LOW, 8'h34);
        wr(IDX_CMP_B_HIGH, 8'h56);
        wr(IDX_CMP_B_LOW, 8'h78);
        wr(IDX_TRIGGER, 8'h00);
        wr(IDX_CONTROL, 8'hD0);
        wr(IDX_CMP_A_HIGH, 8'hFF);
        wr(IDX_TRIGGER, 8'h05);
        rchk(IDX_CMP_A_HIGH, 8'h12);
        rchk(IDX_TRIGGER, 8'h00);
        rchk(IDX_STATUS, 8'h20);
        base = n_brk;
        for (int k = 0; k < 3; k++) begin
            cpu_u.cycle(1'b1, 1'b1, 16'h1000 + 16'(k), 8'h00, 1'b0);
        end
        cpu_u.cycle(1'b1, 1'b1, 16'h1234, 8'h00, 1'b0);
        repeat (2) @(posedge clk);
        rchk(IDX_STATUS, 8'h84);
        chk(16'(n_brk - base), 16'h0001);
        for (int k = 0; k < 4; k++) begin
            rchk(IDX_FIFO_HIGH, k < 3 ? 8'h10 : 8'h12);
            rchk(IDX_FIFO_LOW, k < 3 ? 8'(k) : 8'h34);
        end
        wr(IDX_TRIGGER, 8'h40);
        wr(IDX_CONTROL, 8'hD0);
        cpu_u.cycle(1'b1, 1'b1, 16'h0F00, 8'h00, 1'b0);
        rchk(IDX_STATUS, 8'h20);
        base = n_brk;
        for (int k = 0; k < 8; k++) begin
            cpu_u.cycle(1'b1, 1'b1, k == 0 ? 16'h1234 : 16'h4000 + 16'(k), 8'h00, 1'b0);
            if (k == 3) begin
                rd(IDX_FIFO_LOW, v1);
                rd(IDX_FIFO_LOW, v2);
                chk({8'h00, v1}, 16'h0034);
                chk({8'h00, v2}, 16'h0034);
            end
            if (k == 6) begin
                chk(16'(n_brk - base), 16'h0000);
            end
        end
        repeat (2) @(posedge clk);
        rchk(IDX_STATUS, 8'h88);
        chk(16'(n_brk - base), 16'h0001);
        rchk(IDX_FIFO_HIGH, 8'h12);
        rchk(IDX_FIFO_LOW, 8'h34);
        rchk(IDX_STATUS, 8'h88);
        for (int i = 0; i < 17; i++) begin
            wr(IDX_CONTROL, 8'h80);
            wr(IDX_TRIGGER, t_trg[i]);
            wr(IDX_CONTROL, t_ctl[i]);
            base = n_brk;
            cpu_u.cycle(1'b1, 1'b0, 16'h1234, 8'h78, 1'b0);
            cpu_u.cycle(1'b1, 1'b0, 16'h5678, 8'h78, 1'b0);
            cpu_u.cycle(1'b1, 1'b0, 16'h3000, 8'h11, 1'b1);
            cpu_u.cycle(1'b1, 1'b0, 16'h5679, 8'h22, 1'b0);
            repeat (2) @(posedge clk);
            rd(IDX_STATUS, v1);
            chk(16'(n_brk - base), {15'h0, t_hit[i]});
            chk({15'h0, v1[5]}, {15'h0, !t_hit[i]});
            chk({15'h0, break_tag}, {15'h0, t_ctl[i][5]});
            if (i == 3) begin
                rchk(IDX_FIFO_HIGH, 8'h00);
            end
        end
        wr(IDX_CONTROL, 8'h80);
        cpu_u.cycle(1'b1, 1'b1, 16'h2A5C, 8'h00, 1'b0);
        rd(IDX_FIFO_LOW, v1);
        cpu_u.cycle(1'b1, 1'b1, 16'h3333, 8'h00, 1'b0);
        repeat (7) rd(IDX_FIFO_LOW, v1);
        rchk(IDX_FIFO_HIGH, 8'h2A);
        rchk(IDX_FIFO_LOW, 8'h5C);
        rchk(IDX_FIFO_HIGH, 8'h33);
        @(posedge clk);
        clk_en <= 1'b0;
        wr(IDX_CMP_A_LOW, 8'hAA);
        clk_en <= 1'b1;
        rchk(IDX_CMP_A_LOW, 8'h34);
        wr(IDX_CMP_A_HIGH, 8'h30);
        wr(IDX_CMP_A_LOW, 8'h00);
        wr(IDX_TRIGGER, 8'h80);
        wr(IDX_CONTROL, 8'hD0);
        base = n_brk;
        cpu_u.cycle(1'b1, 1'b0, 16'h3000, 8'h11, 1'b0);
        repeat (2) @(posedge clk);
        chk(16'(n_brk - base), 16'h0000);
        cpu_u.cycle(1'b1, 1'b0, 16'h3000, 8'h11, 1'b1);
        repeat (2) @(posedge clk);
        chk(16'(n_brk - base), 16'h0001);
        give_verdict();
    end
endmodule
